// ---- synth_loop_map.vh ----
// register offsets, field positions, reset values and frame sizes for the
// synthesizer loop configuration register bank.
// assumes it is included once, by the design file only; the bench and checker use literal values.
//
// Function
// [RL1] divide reference by 14-bit ratio when enabled
// [RL2] host never programs ratio zero
// [RL3] use bit 14 selects divider else bypass
// [RL4] auto-bypass bit 15: ratio one bypasses
// [RL5] bit 16 picks sine reference
// [RL6] duty mode stretches prescaler low time
// [RL7] polarity bit inverts detector sense
// [RL8] clearing bit 1 masks up pulses
// [RL9] clearing bit 2 masks down pulses
// [RL10] 3-bit detector delay-line set point
// [RL11] 5-bit up pump current field
// [RL12] 5-bit down pump current field
// [RL13] two 4-bit pump trim fields
// [RL14] two 4-bit pump leakage offset fields
// [RL15] 2-bit dummy amplifier bias field
// [RL16] force enable overrides detector drive
// [RL17] force direction zero up, one down
// [RL18] 16-bit integer divide value
// [RL19] 24-bit fractional divide value
// [RL20] 24-bit modulator seed value
// [RL21] frame: direction, six address, 24 data
// [RL22] autoload reloads seed on fraction change
// [RL23] divider run bit low holds divider reset
// [RL24] host leaves spare words at defaults
`ifndef SYNTH_LOOP_MAP_VH
`define SYNTH_LOOP_MAP_VH

// ---------------------------------------------------------------
// frame layout
// ---------------------------------------------------------------
`define FRAME_BITS 6'h20
`define ADDR_W 6
`define DATA_W 24
`define CNT_ADDR_LAST 6'h06
`define CNT_LAST 6'h1f

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_REF_PATH 6'h03
`define OFS_PRESC_DUTY 6'h04
`define OFS_PD_CFG 6'h05
`define OFS_PD_DELAY 6'h06
`define OFS_PUMP_GAIN 6'h07
`define OFS_PUMP_TRIM 6'h08
`define OFS_PUMP_FORCE 6'h09
`define OFS_SPARE_A 6'h0a
`define OFS_SPARE_B 6'h0b
`define OFS_SPARE_C 6'h0c
`define OFS_SPARE_D 6'h0d
`define OFS_SPARE_E 6'h0e
`define OFS_DIV_INT 6'h0f
`define OFS_DIV_FRAC 6'h10
`define OFS_SEED 6'h11

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_REF_PATH 24'h008001
`define RST_PRESC_DUTY 24'h000001
`define RST_PD_CFG 24'h000006
`define RST_PD_DELAY 24'h000002
`define RST_PUMP_GAIN 24'h000210
`define RST_PUMP_TRIM 24'h020400
`define RST_PUMP_FORCE 24'h000000
`define RST_SPARE_A 24'h000304
`define RST_SPARE_B 24'h000000
`define RST_SPARE_C 24'h000100
`define RST_SPARE_D 24'h000020
`define RST_SPARE_E 24'h000000
`define RST_DIV_INT 24'h0000c8
`define RST_DIV_FRAC 24'h000000
`define RST_SEED 24'h000000

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define REF_RATIO_HI 13
`define REF_USE_BIT 14
`define REF_AUTO_BIT 15
`define REF_SINE_BIT 16
`define REF_RATIO_ONE 14'h0001
`define REF_PATH_MASK 24'h01ffff
`define DUTY_BIT 0
`define DUTY_MASK 24'h000001
`define PD_POL_BIT 0
`define PD_UP_BIT 1
`define PD_DN_BIT 2
`define PD_CFG_MASK 24'h000007
`define PD_DELAY_MASK 24'h000007
`define PD_DELAY_HI 2
`define GAIN_UP_LO 0
`define GAIN_DN_LO 5
`define GAIN_MASK 24'h0003ff
`define TRIM_UP_LO 0
`define TRIM_DN_LO 4
`define LEAK_UP_LO 8
`define LEAK_DN_LO 12
`define AMP_BIAS_LO 16
`define TRIM_MASK 24'h03ffff
`define FORCE_EN_BIT 0
`define FORCE_DIR_BIT 1
`define FORCE_MASK 24'h000003
`define INT_MASK 24'h00ffff
`define INT_HI 15

`endif

// ---- synth_loop_config_registers.v ----
// serial-loaded configuration bank for the synthesizer loop: reference
// path, detector, charge pump and modulator divide values.
// assumes serial_clk is a plain input sampled on clk_sys, which runs at
// least several times faster than the serial clock, and that the enable
// and modulator registers live elsewhere and arrive as level inputs.
`include "synth_loop_map.vh"
`default_nettype none

module synth_loop_config_registers (
  // system
  input wire clk_sys,
  input wire rst,
  // three-wire serial port, active-high select
  input wire serial_select,
  input wire serial_clk,
  input wire serial_in,
  // levels from the enable and modulator registers
  input wire ref_div_run,
  input wire seed_autoload,
  // detector edges in, pump commands out
  input wire pd_up_raw,
  input wire pd_dn_raw,
  output reg pump_up,
  output reg pump_dn,
  // reference path controls
  output reg ref_div_active,
  output reg [13:0] ref_div_ratio,
  output reg ref_sine_select,
  output reg prescaler_long_low,
  // detector and pump analog codes
  output reg [2:0] pd_delay_sel,
  output reg [4:0] pump_up_current,
  output reg [4:0] pump_down_current,
  output reg [3:0] pump_up_trim,
  output reg [3:0] pump_down_trim,
  output reg [3:0] pump_up_leak,
  output reg [3:0] pump_down_leak,
  output reg [1:0] pump_dummy_amp_bias,
  // modulator values
  output reg [15:0] div_integer,
  output reg [23:0] div_fraction,
  output reg [23:0] mod_seed,
  output reg seed_load
);

  // ---------------------------------------------------------------
  // serial frame capture
  // ---------------------------------------------------------------
  reg sclk_d_reg; // previous serial clock sample, for rising edges
  reg [5:0] bit_cnt_reg; // rising edges seen in this frame
  reg [`ADDR_W-1:0] addr_reg; // shifted address bits
  reg [`DATA_W-1:0] data_reg; // shifted data bits
  reg dir_reg; // direction bit, low means write
  reg wr_stb_reg; // one-cycle write strobe
  reg [`ADDR_W-1:0] wr_addr_reg;
  reg [`DATA_W-1:0] wr_data_reg;
  wire sclk_rise;

  assign sclk_rise = serial_clk & ~sclk_d_reg;

  // shift on each rising serial clock; the 32nd edge closes a frame.
  // a frame cut short by dropping select is discarded, never applied.
  always @(posedge clk_sys) begin
    if (rst) begin
      sclk_d_reg <= 1'b0;
      bit_cnt_reg <= 6'h00;
      addr_reg <= 6'h00;
      data_reg <= 24'h000000;
      dir_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= 6'h00;
      wr_data_reg <= 24'h000000;
    end else begin
      sclk_d_reg <= serial_clk;
      wr_stb_reg <= 1'b0;
      if (!serial_select) begin
        // idle between frames
        bit_cnt_reg <= 6'h00;
      end else if (sclk_rise && bit_cnt_reg != `FRAME_BITS) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
        // [RL21] frame bit order
        if (bit_cnt_reg == 6'h00) begin
          dir_reg <= serial_in;
        end else if (bit_cnt_reg <= `CNT_ADDR_LAST) begin
          addr_reg <= {addr_reg[`ADDR_W-2:0], serial_in};
        end else begin
          data_reg <= {data_reg[`DATA_W-2:0], serial_in};
        end
        // [RL21] last edge commits write
        if (bit_cnt_reg == `CNT_LAST && !dir_reg) begin
          wr_stb_reg <= 1'b1;
          wr_addr_reg <= addr_reg;
          // data came on edges 8 to 31; the bit on edge 32 is not data
          wr_data_reg <= data_reg;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  reg [23:0] ref_path_reg;
  reg [23:0] presc_duty_reg;
  reg [23:0] pd_cfg_reg;
  reg [23:0] pd_delay_reg;
  reg [23:0] pump_gain_reg;
  reg [23:0] pump_trim_reg;
  reg [23:0] pump_force_reg;
  reg [23:0] spare_a_reg; // spare words are stored only, they steer nothing
  reg [23:0] spare_b_reg;
  reg [23:0] spare_c_reg;
  reg [23:0] spare_d_reg;
  reg [23:0] spare_e_reg;
  reg [23:0] div_int_reg;
  reg [23:0] div_frac_reg;
  reg [23:0] seed_reg;
  reg frac_wr_reg; // fraction was written last cycle

  // decode the committed write; unmapped offsets are ignored.
  // unused upper bits are masked so they are stored as zero.
  always @(posedge clk_sys) begin
    if (rst) begin
      ref_path_reg <= `RST_REF_PATH;
      presc_duty_reg <= `RST_PRESC_DUTY;
      pd_cfg_reg <= `RST_PD_CFG;
      pd_delay_reg <= `RST_PD_DELAY;
      pump_gain_reg <= `RST_PUMP_GAIN;
      pump_trim_reg <= `RST_PUMP_TRIM;
      pump_force_reg <= `RST_PUMP_FORCE;
      spare_a_reg <= `RST_SPARE_A;
      spare_b_reg <= `RST_SPARE_B;
      spare_c_reg <= `RST_SPARE_C;
      spare_d_reg <= `RST_SPARE_D;
      spare_e_reg <= `RST_SPARE_E;
      div_int_reg <= `RST_DIV_INT;
      div_frac_reg <= `RST_DIV_FRAC;
      seed_reg <= `RST_SEED;
      frac_wr_reg <= 1'b0;
    end else begin
      frac_wr_reg <= 1'b0;
      if (wr_stb_reg) begin
        case (wr_addr_reg)
          // [RL1] ratio and path select
          `OFS_REF_PATH: ref_path_reg <= wr_data_reg & `REF_PATH_MASK;
          // [RL6] duty mode bit
          `OFS_PRESC_DUTY: presc_duty_reg <= wr_data_reg & `DUTY_MASK;
          // [RL7] polarity and masks
          `OFS_PD_CFG: pd_cfg_reg <= wr_data_reg & `PD_CFG_MASK;
          // [RL10] delay set point
          `OFS_PD_DELAY: pd_delay_reg <= wr_data_reg & `PD_DELAY_MASK;
          // [RL11] pump current codes
          `OFS_PUMP_GAIN: pump_gain_reg <= wr_data_reg & `GAIN_MASK;
          // [RL13] trim, leak and bias
          `OFS_PUMP_TRIM: pump_trim_reg <= wr_data_reg & `TRIM_MASK;
          // [RL16] force controls
          `OFS_PUMP_FORCE: pump_force_reg <= wr_data_reg & `FORCE_MASK;
          `OFS_SPARE_A: spare_a_reg <= wr_data_reg;
          `OFS_SPARE_B: spare_b_reg <= wr_data_reg;
          `OFS_SPARE_C: spare_c_reg <= wr_data_reg;
          `OFS_SPARE_D: spare_d_reg <= wr_data_reg;
          `OFS_SPARE_E: spare_e_reg <= wr_data_reg;
          // [RL18] integer divide value
          `OFS_DIV_INT: div_int_reg <= wr_data_reg & `INT_MASK;
          // [RL19] fraction write noted
          `OFS_DIV_FRAC: begin
            div_frac_reg <= wr_data_reg;
            frac_wr_reg <= 1'b1;
          end
          // [RL20] seed value
          `OFS_SEED: seed_reg <= wr_data_reg;
          default: begin
            // unmapped offset, write dropped
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // steering logic and outputs
  // ---------------------------------------------------------------
  wire [13:0] ratio_w;
  wire use_div_w;
  reg up_sel_next;
  reg dn_sel_next;
  // reset words, sliced so outputs wake up matching their registers
  wire [23:0] ref_rst_w;
  wire [23:0] duty_rst_w;
  wire [23:0] delay_rst_w;
  wire [23:0] gain_rst_w;
  wire [23:0] trim_rst_w;
  wire [23:0] int_rst_w;
  wire [23:0] frac_rst_w;
  wire [23:0] seed_rst_w;

  assign ref_rst_w = `RST_REF_PATH;
  assign duty_rst_w = `RST_PRESC_DUTY;
  assign delay_rst_w = `RST_PD_DELAY;
  assign gain_rst_w = `RST_PUMP_GAIN;
  assign trim_rst_w = `RST_PUMP_TRIM;
  assign int_rst_w = `RST_DIV_INT;
  assign frac_rst_w = `RST_DIV_FRAC;
  assign seed_rst_w = `RST_SEED;
  assign ratio_w = ref_path_reg[`REF_RATIO_HI:0];
  // [RL4] auto-bypass on ratio one
  assign use_div_w = ref_path_reg[`REF_AUTO_BIT] ? (ratio_w != `REF_RATIO_ONE)
                                                  : ref_path_reg[`REF_USE_BIT];

  // detector to pump path: polarity, masking, then forcing on top
  always @* begin
    // [RL7] polarity swaps up and down
    if (pd_cfg_reg[`PD_POL_BIT]) begin
      up_sel_next = pd_dn_raw;
      dn_sel_next = pd_up_raw;
    end else begin
      up_sel_next = pd_up_raw;
      dn_sel_next = pd_dn_raw;
    end
    // [RL8] up pulse mask
    up_sel_next = up_sel_next & pd_cfg_reg[`PD_UP_BIT];
    // [RL9] down pulse mask
    dn_sel_next = dn_sel_next & pd_cfg_reg[`PD_DN_BIT];
    // [RL16] force overrides detector
    if (pump_force_reg[`FORCE_EN_BIT]) begin
      // [RL17] direction zero up
      up_sel_next = ~pump_force_reg[`FORCE_DIR_BIT];
      dn_sel_next = pump_force_reg[`FORCE_DIR_BIT];
    end
  end

  // every output is registered; the pump path costs one clk_sys of delay,
  // accepted since the pump only needs a cleaned, glitch-free command.
  always @(posedge clk_sys) begin
    if (rst) begin
      pump_up <= 1'b0;
      pump_dn <= 1'b0;
      ref_div_active <= 1'b0;
      ref_div_ratio <= ref_rst_w[`REF_RATIO_HI:0];
      ref_sine_select <= ref_rst_w[`REF_SINE_BIT];
      prescaler_long_low <= duty_rst_w[`DUTY_BIT];
      pd_delay_sel <= delay_rst_w[`PD_DELAY_HI:0];
      pump_up_current <= gain_rst_w[`GAIN_UP_LO+4:`GAIN_UP_LO];
      pump_down_current <= gain_rst_w[`GAIN_DN_LO+4:`GAIN_DN_LO];
      pump_up_trim <= trim_rst_w[`TRIM_UP_LO+3:`TRIM_UP_LO];
      pump_down_trim <= trim_rst_w[`TRIM_DN_LO+3:`TRIM_DN_LO];
      pump_up_leak <= trim_rst_w[`LEAK_UP_LO+3:`LEAK_UP_LO];
      pump_down_leak <= trim_rst_w[`LEAK_DN_LO+3:`LEAK_DN_LO];
      pump_dummy_amp_bias <= trim_rst_w[`AMP_BIAS_LO+1:`AMP_BIAS_LO];
      div_integer <= int_rst_w[`INT_HI:0];
      div_fraction <= frac_rst_w;
      mod_seed <= seed_rst_w;
      seed_load <= 1'b0;
    end else begin
      pump_up <= up_sel_next;
      pump_dn <= dn_sel_next;
      // [RL3] use bit picks divider
      // [RL23] run bit low bypasses
      ref_div_active <= use_div_w & ref_div_run;
      // [RL1] ratio to divider
      ref_div_ratio <= ratio_w;
      // [RL5] sine reference select
      ref_sine_select <= ref_path_reg[`REF_SINE_BIT];
      // [RL6] long prescaler low time
      prescaler_long_low <= presc_duty_reg[`DUTY_BIT];
      // [RL10] delay code out
      pd_delay_sel <= pd_delay_reg[`PD_DELAY_HI:0];
      // [RL11] up current code
      pump_up_current <= pump_gain_reg[`GAIN_UP_LO+4:`GAIN_UP_LO];
      // [RL12] down current code
      pump_down_current <= pump_gain_reg[`GAIN_DN_LO+4:`GAIN_DN_LO];
      // [RL13] trim codes out
      pump_up_trim <= pump_trim_reg[`TRIM_UP_LO+3:`TRIM_UP_LO];
      pump_down_trim <= pump_trim_reg[`TRIM_DN_LO+3:`TRIM_DN_LO];
      // [RL14] leakage codes out
      pump_up_leak <= pump_trim_reg[`LEAK_UP_LO+3:`LEAK_UP_LO];
      pump_down_leak <= pump_trim_reg[`LEAK_DN_LO+3:`LEAK_DN_LO];
      // [RL15] bias code out
      pump_dummy_amp_bias <= pump_trim_reg[`AMP_BIAS_LO+1:`AMP_BIAS_LO];
      // [RL18] integer value out
      div_integer <= div_int_reg[`INT_HI:0];
      // [RL19] fraction value out
      div_fraction <= div_frac_reg;
      // [RL20] seed value out
      mod_seed <= seed_reg;
      // [RL22] reload on fraction change
      seed_load <= frac_wr_reg & seed_autoload;
    end
  end

endmodule

`default_nettype wire

// ---- synth_loop_host_model.sv ----
// host model: writes whole or cut-short frames on the three-wire serial port
// assumes clk_sys comes from the bench; lines change just after its rising edge
`default_nettype none
module synth_loop_host_model (
  // system
  input wire logic clk_sys,
  // serial port
  output logic serial_select,
  output logic serial_clk,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: select low, clock parked low so release of reset sees no rise
  initial begin
    serial_select = 1'b0;
    serial_clk = 1'b0;
    serial_in = 1'b1;
  end
  // ---------------------------------------------------------------
  // frame sender
  // ---------------------------------------------------------------
  // msb first, data set while clock low
  // n below 32 drops select early; clock high and low two cycles each
  task automatic send(input logic [31:0] frame, input int n);
    int i;
    @(posedge clk_sys);
    serial_select <= 1'b1;
    for (i = 0; i < n; i++) begin
      @(posedge clk_sys);
      serial_clk <= 1'b0;
      serial_in <= frame[31-i];
      repeat (2) @(posedge clk_sys);
      serial_clk <= 1'b1;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
    serial_clk <= 1'b0;
    @(posedge clk_sys);
    serial_select <= 1'b0;
    // released data line must not keep showing the last bit
    serial_in <= ~serial_in;
  endtask
endmodule
`default_nettype wire

// ---- synth_loop_config_assertions.sv ----
// checker for the loop configuration bank, bound to its top module
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module synth_loop_config_checker (
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // inputs watched
  input wire logic serial_select,
  input wire logic serial_clk,
  input wire logic ref_div_run,
  input wire logic pd_up_raw,
  input wire logic pd_dn_raw,
  // outputs watched
  input wire logic pump_up,
  input wire logic pump_dn,
  input wire logic ref_div_active,
  input wire logic [13:0] ref_div_ratio,
  input wire logic prescaler_long_low,
  input wire logic [2:0] pd_delay_sel,
  input wire logic [4:0] pump_up_current,
  input wire logic [15:0] div_integer,
  input wire logic [23:0] div_fraction,
  input wire logic seed_load
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic sclk_d; // serial clock as last sampled
  logic [5:0] rises; // rises seen in this select
  logic [2:0] age; // cycles since a 32nd rise, saturates at 7
  // config may only move a few cycles after a complete frame
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_d <= 1'b0;
      rises <= 6'h00;
      age <= 3'h7;
    end else begin
      sclk_d <= serial_clk;
      if (!serial_select) rises <= 6'h00;
      else if (serial_clk && !sclk_d && rises != 6'h20) rises <= rises + 6'h01;
      if (serial_select && serial_clk && !sclk_d && rises == 6'h1f) age <= 3'h0;
      else if (age != 3'h7) age <= age + 3'h1;
    end
  end
  sequence run_low_twice;
    !ref_div_run ##1 !ref_div_run;
  endsequence
  sequence frame_recent;
    age <= 3'h5;
  endsequence
  a_reset_values: assert property (disable iff (1'b0) rst |=> ref_div_ratio == 14'h0001
    && prescaler_long_low && pd_delay_sel == 3'h2 && pump_up_current == 5'h10
    && div_integer == 16'h00c8 && !pump_up && !pump_dn && !ref_div_active && !seed_load)
    else $error("outputs not at reset values");
  a_run_low_bypass: assert property (run_low_twice |-> !ref_div_active)
    else $error("divider active while held in reset");
  a_seed_one_cycle: assert property (seed_load |=> !seed_load)
    else $error("seed load longer than one cycle");
  a_seed_after_frame: assert property ($rose(seed_load) |-> frame_recent)
    else $error("seed load without a frame");
  a_ratio_after_frame: assert property ($changed(ref_div_ratio) |-> frame_recent)
    else $error("ratio moved without a frame");
  a_int_after_frame: assert property (!$stable(div_integer) |-> frame_recent)
    else $error("integer moved without a frame");
  a_frac_after_frame: assert property (div_fraction != $past(div_fraction) |-> frame_recent)
    else $error("fraction moved without a frame");
  a_delay_after_frame: assert property ($changed(pd_delay_sel) |-> frame_recent)
    else $error("delay code moved without a frame");
  a_pump_pair_cause: assert property (pump_up && pump_dn |-> $past(pd_up_raw) && $past(pd_dn_raw))
    else $error("both pump commands without both detector pulses");
  c_seed_load: cover property (seed_load);
endmodule
bind synth_loop_config_registers synth_loop_config_checker chk_u (.clk_sys, .rst,
  .serial_select, .serial_clk, .ref_div_run, .pd_up_raw, .pd_dn_raw, .pump_up, .pump_dn,
  .ref_div_active, .ref_div_ratio, .prescaler_long_low, .pd_delay_sel, .pump_up_current,
  .div_integer, .div_fraction, .seed_load);
`default_nettype wire

// ---- synth_loop_config_registers_test.sv ----
// self-checking bench: serial writes, then checks of the decoded outputs
// assumes the host model drives the serial port and nothing reads back
`default_nettype none
module synth_loop_config_registers_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, ref_div_run, seed_autoload, pd_up_raw, pd_dn_raw;
  wire serial_select, serial_clk, serial_in, pump_up, pump_dn, ref_div_active;
  wire ref_sine_select, prescaler_long_low, seed_load;
  wire [13:0] ref_div_ratio;
  wire [2:0] pd_delay_sel;
  wire [4:0] pump_up_current, pump_down_current;
  wire [3:0] pump_up_trim, pump_down_trim, pump_up_leak, pump_down_leak;
  wire [1:0] pump_dummy_amp_bias;
  wire [15:0] div_integer;
  wire [23:0] div_fraction, mod_seed;
  int n_errors = 0;
  int compares = 0;
  int n_seed = 0; // seed load pulses seen
  int i;
  logic [23:0] ref_word [6] = '{24'h008005, 24'h008001, 24'h000005, 24'h004005, 24'h004005,
    24'h017fff};
  logic ref_run [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic ref_act [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  synth_loop_host_model host_u (.clk_sys, .serial_select, .serial_clk, .serial_in);
  synth_loop_config_registers dut_u (.clk_sys, .rst, .serial_select, .serial_clk, .serial_in,
    .ref_div_run, .seed_autoload, .pd_up_raw, .pd_dn_raw, .pump_up, .pump_dn, .ref_div_active,
    .ref_div_ratio, .ref_sine_select, .prescaler_long_low, .pd_delay_sel, .pump_up_current,
    .pump_down_current, .pump_up_trim, .pump_down_trim, .pump_up_leak, .pump_down_leak,
    .pump_dummy_amp_bias, .div_integer, .div_fraction, .mod_seed, .seed_load);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (seed_load === 1'b1) n_seed <= n_seed + 1;
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // full write frame, then room for the three-cycle update
  task automatic wr(input logic [5:0] addr, input logic [23:0] data);
    // direction, address, data, then one pad bit for the 32nd edge
    host_u.send({1'b0, addr, data, 1'b0}, 32);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic pump_chk(input logic up, input logic dn, input logic [1:0] exp);
    @(posedge clk_sys);
    pd_up_raw <= up;
    pd_dn_raw <= dn;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check("pump", {pump_up, pump_dn}, exp);
  endtask
  task automatic final_report;
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_errors++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    ref_div_run = 1'b1;
    seed_autoload = 1'b0;
    pd_up_raw = 1'b0;
    pd_dn_raw = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("ref", {ref_div_active, ref_div_ratio, ref_sine_select}, 16'h0002);
    check("codes", {pd_delay_sel, pump_up_current, pump_down_current, pump_up_trim,
      pump_down_trim, pump_up_leak, pump_down_leak, pump_dummy_amp_bias}, 31'h28400102);
    check("integer reset", div_integer, 16'h00c8);
    check("mod reset", {div_fraction, mod_seed, seed_load}, 49'h0);
    // ratios kept nonzero by the host
    for (i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      ref_div_run <= ref_run[i];
      wr(6'h03, ref_word[i]);
      check("ref", {ref_div_active, ref_div_ratio, ref_sine_select},
        {ref_act[i], ref_word[i][13:0], ref_word[i][16]});
    end
    wr(6'h04, 24'h000000);
    check("duty", prescaler_long_low, 1'b0);
    wr(6'h06, 24'hfffff9);
    check("delay", pd_delay_sel, 3'h1);
    wr(6'h07, 24'hfff83e);
    check("up current", pump_up_current, 5'h1e);
    check("down current", pump_down_current, 5'h01);
    wr(6'h08, 24'hfda5c3);
    check("trims", {pump_up_trim, pump_down_trim}, 8'h3c);
    check("leaks", {pump_up_leak, pump_down_leak}, 8'h5a);
    check("bias", pump_dummy_amp_bias, 2'h1);
    wr(6'h0f, 24'hab1234);
    check("integer", div_integer, 16'h1234);
    wr(6'h11, 24'h3c96e1);
    check("seed", mod_seed, 24'h3c96e1);
    wr(6'h10, 24'h5a5a5a);
    check("fraction", div_fraction, 24'h5a5a5a);
    check("no autoload", n_seed, 0);
    @(posedge clk_sys);
    seed_autoload <= 1'b1;
    wr(6'h10, 24'ha5a5a5);
    check("autoload", n_seed, 1);
    host_u.send({1'b1, 6'h0f, 24'h000777, 1'b0}, 32);
    host_u.send({1'b0, 6'h0f, 24'h000999, 1'b0}, 20);
    wr(6'h12, 24'h000555);
    check("refused", div_integer, 16'h1234);
    for (i = 0; i < 8; i++) begin
      wr(6'h05, 24'(i));
      pump_chk(1'b1, 1'b0, {~i[0] & i[1], i[0] & i[2]});
    end
    wr(6'h05, 24'h000006);
    pump_chk(1'b1, 1'b1, 2'b11);
    wr(6'h05, 24'h000000);
    pump_chk(1'b1, 1'b1, 2'b00);
    wr(6'h09, 24'h000001);
    pump_chk(1'b0, 1'b1, 2'b10);
    wr(6'h09, 24'h000003);
    pump_chk(1'b1, 1'b0, 2'b01);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("rereset", {div_integer, ref_div_ratio}, 30'h00320001);
    final_report;
  end
endmodule
`default_nettype wire
